// ==== design/force_scaler.sv ====
// restoring divider that turns a scaled force reference into tenths of a percent of rated force
`timescale 1ns/1ps
`include "servo_regs.svh"
module force_scaler import servo_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [`QUO_W-1:0] dividend,
    input wire logic [`GAIN_W-1:0] divisor,
    output logic busy,
    output logic done,
    output logic [`QUO_W-1:0] quotient
);

    div_s s_reg;
    div_s s_next;
    logic [7:0] trial;

    always_comb begin
        s_next = s_reg;
        trial = {s_reg.rem[6:0], s_reg.quo[`QUO_W-1]};
        s_next.done = 1'b0;
        unique case (s_reg.state)
            DIV_IDLE: begin
                if (start) begin
                    s_next.state = DIV_RUN;
                    s_next.cnt = 5'h00;
                    s_next.rem = 8'h00;
                    s_next.quo = dividend;
                    s_next.div = divisor;
                end
            end
            DIV_RUN: begin
                // remainder stays below the divisor, so seven bits hold it
                if (trial >= {1'b0, s_reg.div}) begin
                    s_next.rem = trial - {1'b0, s_reg.div};
                    s_next.quo = {s_reg.quo[`QUO_W-2:0], 1'b1};
                end else begin
                    s_next.rem = trial;
                    s_next.quo = {s_reg.quo[`QUO_W-2:0], 1'b0};
                end
                s_next.cnt = s_reg.cnt + 5'h01;
                if (s_reg.cnt == `DIV_LAST) begin
                    s_next.state = DIV_IDLE;
                    s_next.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = (s_reg.state == DIV_RUN);
    assign done = s_reg.done;
    assign quotient = s_reg.quo;

endmodule

// ==== design/servo_near_inhibit_force_ref.sv ====
// positioning near/done flags, reference pulse inhibit and force reference scaling
`timescale 1ns/1ps
`include "servo_regs.svh"
module servo_near_inhibit_force_ref import servo_pkg::*; (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic PULSE_FWD,
    input wire logic PULSE_REV,
    input wire logic FB_FWD,
    input wire logic FB_REV,
    input wire logic PROPORTIONAL_CTRL_INPUT_N,
    input wire logic PULSE_BLOCK_INPUT_N,
    input wire logic [3:0] CONTROL_MODE_DIGIT,
    input wire logic INHIBIT_ENABLE,
    input wire logic INHIBIT_SRC_SEL,
    input wire logic PULSE_BLOCK_ASSIGNED,
    input wire logic OUTPUT_ASSIGN_SETTING_NEAR,
    input wire logic [`DONE_W-1:0] DONE_WIDTH_SETTING,
    input wire logic [`NEAR_W-1:0] NEAR_WIDTH_SETTING,
    input wire logic [`GAIN_W-1:0] FORCE_INPUT_GAIN,
    input wire logic signed [`FORCE_W-1:0] FORCE_REF_MV,
    output logic NEAR_FLAG_N,
    output logic POSITION_DONE_FLAG_N,
    output logic MOTOR_LOCK,
    output logic signed [`ERR_W-1:0] POSITION_ERROR,
    output logic signed [`FORCE_W-1:0] FORCE_CMD,
    output logic FORCE_DIR
);

    // ----------------------------------------
    // state and decode
    // ----------------------------------------
    ctrl_s s_reg;
    ctrl_s s_next;

    logic [`SYNC_N-1:0] pins;
    logic [3:0] edges;
    logic pos_mode;
    logic force_ok;
    logic inhibit_now;
    logic signed [2:0] delta;
    logic [`ERR_W-1:0] err_mag;
    logic [`DONE_W-1:0] done_eff;
    logic [`NEAR_W-1:0] near_eff;
    logic near_now;
    logic done_now;
    logic [`GAIN_W-1:0] gain_eff;
    logic [`FORCE_W-1:0] ref_abs;
    logic [`FORCE_W-1:0] ref_clamped;
    logic [`QUO_W-1:0] dividend;
    logic div_busy;
    logic div_done;
    logic [`QUO_W-1:0] quotient;
    logic [`FORCE_W-1:0] q16;

    assign pins = {PULSE_BLOCK_INPUT_N, PROPORTIONAL_CTRL_INPUT_N, FB_REV, FB_FWD, PULSE_REV, PULSE_FWD};
    // edges are taken from the second stage only; the first stage may be metastable
    assign edges = s_reg.sync2[3:0] & ~s_reg.prev[3:0];
    assign pos_mode = (CONTROL_MODE_DIGIT == `CTRL_MODE_POSITION);
    assign force_ok = (CONTROL_MODE_DIGIT == `CTRL_MODE_FORCE_A) ||
                      (CONTROL_MODE_DIGIT == `CTRL_MODE_FORCE_B) ||
                      (CONTROL_MODE_DIGIT == `CTRL_MODE_FORCE_C) ||
                      (CONTROL_MODE_DIGIT == `CTRL_MODE_FORCE_D);

    // ----------------------------------------
    // hold source selection
    // ----------------------------------------
    always_comb begin
        inhibit_now = 1'b0;
        if (pos_mode && INHIBIT_ENABLE) begin
            if (!INHIBIT_SRC_SEL) begin
                inhibit_now = ~s_reg.sync2[`SYN_PROP];
            end else begin
                // an unassigned block terminal leaves the hold released
                inhibit_now = PULSE_BLOCK_ASSIGNED & ~s_reg.sync2[`SYN_BLOCK];
            end
        end
    end

    // ----------------------------------------
    // position error and flag thresholds
    // ----------------------------------------
    always_comb begin
        delta = 3'h0;
        if (pos_mode && !s_reg.hold) begin
            delta = 3'(edges[`SYN_REF_FWD]) - 3'(edges[`SYN_REF_REV]);
        end
        delta = delta - 3'(edges[`SYN_FB_FWD]) + 3'(edges[`SYN_FB_REV]);
    end

    assign err_mag = s_reg.err[`ERR_W-1] ? `ERR_W'(-s_reg.err) : `ERR_W'(s_reg.err);
    assign done_eff = (DONE_WIDTH_SETTING > `DONE_WIDTH_MAX) ? `DONE_WIDTH_MAX : DONE_WIDTH_SETTING;
    // a near width below the done width is widened so an assigned near flag never trails done
    assign near_eff = (NEAR_WIDTH_SETTING < {8'h00, done_eff}) ? {8'h00, done_eff} : NEAR_WIDTH_SETTING;
    assign done_now = pos_mode && (err_mag < {24'h000000, done_eff});
    assign near_now = pos_mode && OUTPUT_ASSIGN_SETTING_NEAR && (err_mag < {16'h0000, near_eff});

    // ----------------------------------------
    // force reference scaling
    // ----------------------------------------
    assign gain_eff = (FORCE_INPUT_GAIN < `GAIN_MIN) ? `GAIN_MIN :
                      (FORCE_INPUT_GAIN > `GAIN_MAX) ? `GAIN_MAX : FORCE_INPUT_GAIN;
    assign ref_abs = FORCE_REF_MV[`FORCE_W-1] ? `FORCE_W'(-FORCE_REF_MV) : `FORCE_W'(FORCE_REF_MV);
    // inputs past the allowed 12 V are treated as 12 V rather than wrapping
    assign ref_clamped = (ref_abs > `FORCE_REF_MAX_MV) ? `FORCE_REF_MAX_MV : ref_abs;
    // tenths of a percent = mV * 10 / gain, gain being in 0.1 V per rated force
    assign dividend = `QUO_W'(ref_clamped) * `FORCE_SCALE;
    assign q16 = quotient[`FORCE_W-1:0];

    force_scaler force_scaler_i (
        .clk(REF_CLK),
        .reset(RESET),
        .start(~div_busy),
        .dividend(dividend),
        .divisor(gain_eff),
        .busy(div_busy),
        .done(div_done),
        .quotient(quotient)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.sync1 = pins;
        s_next.sync2 = s_reg.sync1;
        s_next.prev = s_reg.sync2;
        s_next.err = s_reg.err + {{(`ERR_W-3){delta[2]}}, delta};
        s_next.hold = inhibit_now;
        s_next.near_n = ~near_now;
        s_next.done_n = ~done_now;
        if (div_done) begin
            if (!force_ok) begin
                s_next.force_cmd = '0;
                s_next.force_dir = 1'b1;
            end else if (s_reg.ref_neg) begin
                s_next.force_cmd = `FORCE_W'(-q16);
                s_next.force_dir = (q16 == '0);
            end else begin
                s_next.force_cmd = q16;
                s_next.force_dir = 1'b1;
            end
        end
        if (!div_busy) begin
            s_next.ref_neg = FORCE_REF_MV[`FORCE_W-1];
            s_next.ref_lat = dividend;
            s_next.gain_lat = gain_eff;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            s_reg <= '0;
            s_reg.sync1 <= `SYNC_RESET;
            s_reg.sync2 <= `SYNC_RESET;
            s_reg.prev <= `SYNC_RESET;
            s_reg.near_n <= 1'b1;
            s_reg.done_n <= 1'b1;
            s_reg.force_dir <= 1'b1;
            s_reg.gain_lat <= `GAIN_DEFAULT;
        end else begin
            s_reg <= s_next;
        end
    end

    assign NEAR_FLAG_N = s_reg.near_n;
    assign POSITION_DONE_FLAG_N = s_reg.done_n;
    assign MOTOR_LOCK = s_reg.hold;
    assign POSITION_ERROR = s_reg.err;
    assign FORCE_CMD = s_reg.force_cmd;
    assign FORCE_DIR = s_reg.force_dir;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    logic [26:0] chk_prod;
    assign chk_prod = 27'(quotient) * 27'(s_reg.gain_lat);

    sequence seq_prop_low;
        (pos_mode && INHIBIT_ENABLE && !INHIBIT_SRC_SEL && !PROPORTIONAL_CTRL_INPUT_N)[*4];
    endsequence

    sequence seq_prop_high;
        (pos_mode && INHIBIT_ENABLE && !INHIBIT_SRC_SEL && PROPORTIONAL_CTRL_INPUT_N)[*4];
    endsequence

    sequence seq_block_low;
        (pos_mode && INHIBIT_ENABLE && INHIBIT_SRC_SEL && PULSE_BLOCK_ASSIGNED && !PULSE_BLOCK_INPUT_N)[*4];
    endsequence

    sequence seq_block_unassigned;
        (pos_mode && INHIBIT_ENABLE && INHIBIT_SRC_SEL && !PULSE_BLOCK_ASSIGNED)[*4];
    endsequence

    sequence seq_div_quiet;
        (!div_done)[*8];
    endsequence

    a_near_inside: assert property (@(posedge REF_CLK) disable iff (RESET)
        near_now |=> !NEAR_FLAG_N) else $error("near flag not low inside near width");

    a_near_unrouted: assert property (@(posedge REF_CLK) disable iff (RESET)
        !OUTPUT_ASSIGN_SETTING_NEAR |=> NEAR_FLAG_N) else $error("near flag driven while unassigned");

    a_done_width: assert property (@(posedge REF_CLK) disable iff (RESET)
        (err_mag >= {24'h000000, done_eff}) |=> POSITION_DONE_FLAG_N) else $error("done flag low outside width");

    a_hold_freeze: assert property (@(posedge REF_CLK) disable iff (RESET)
        (MOTOR_LOCK && edges[3:2] == 2'h0) |=> $stable(POSITION_ERROR)) else $error("pulse counted during hold");

    a_prop_lock: assert property (@(posedge REF_CLK) disable iff (RESET)
        seq_prop_low |-> MOTOR_LOCK) else $error("low hold input did not lock");

    a_prop_release: assert property (@(posedge REF_CLK) disable iff (RESET)
        seq_prop_high |-> !MOTOR_LOCK) else $error("high hold input did not release");

    a_block_lock: assert property (@(posedge REF_CLK) disable iff (RESET)
        seq_block_low |-> MOTOR_LOCK) else $error("pulse block input did not lock");

    a_block_unassigned: assert property (@(posedge REF_CLK) disable iff (RESET)
        seq_block_unassigned |-> !MOTOR_LOCK) else $error("unassigned block input locked");

    // the latched gain must be the setting itself when it is in range, and a clamp otherwise
    a_gain_range: assert property (@(posedge REF_CLK) disable iff (RESET)
        !div_busy |=> s_reg.gain_lat >= `GAIN_MIN && s_reg.gain_lat <= `GAIN_MAX &&
            (!($past(FORCE_INPUT_GAIN) inside {[`GAIN_MIN:`GAIN_MAX]}) || s_reg.gain_lat == $past(FORCE_INPUT_GAIN)))
        else $error("gain outside 10 to 100");

    a_force_ratio: assert property (@(posedge REF_CLK) disable iff (RESET)
        div_done |-> (chk_prod <= 27'(s_reg.ref_lat)) && (27'(s_reg.ref_lat) - chk_prod < 27'(s_reg.gain_lat)))
        else $error("force quotient wrong");

    a_force_sign: assert property (@(posedge REF_CLK) disable iff (RESET)
        (FORCE_CMD > 0 |-> FORCE_DIR) and (FORCE_CMD < 0 |-> !FORCE_DIR)) else $error("force direction wrong");

    a_force_gate: assert property (@(posedge REF_CLK) disable iff (RESET)
        (div_done && !force_ok) |=> FORCE_CMD == '0) else $error("force used outside force modes");

    a_near_first: assert property (@(posedge REF_CLK) disable iff (RESET)
        (!POSITION_DONE_FLAG_N && $past(OUTPUT_ASSIGN_SETTING_NEAR)) |-> !NEAR_FLAG_N)
        else $error("done flag ahead of near flag");

    a_ref_counted: assert property (@(posedge REF_CLK) disable iff (RESET)
        (pos_mode && !MOTOR_LOCK && edges == 4'h1) |=> POSITION_ERROR == $past(POSITION_ERROR) + 32'h00000001)
        else $error("reference pulse not counted");

    a_travel_counted: assert property (@(posedge REF_CLK) disable iff (RESET)
        (edges == 4'h4) |=> POSITION_ERROR == $past(POSITION_ERROR) - 32'h00000001)
        else $error("motor travel not counted");

    a_mode_gate: assert property (@(posedge REF_CLK) disable iff (RESET)
        (!pos_mode && edges[3:2] == 2'h0) |=> $stable(POSITION_ERROR))
        else $error("reference pulse counted outside position control");

    a_hold_mode: assert property (@(posedge REF_CLK) disable iff (RESET)
        !pos_mode |=> !MOTOR_LOCK)
        else $error("hold active outside position control");

    a_near_outside: assert property (@(posedge REF_CLK) disable iff (RESET)
        !near_now |=> NEAR_FLAG_N)
        else $error("near flag low outside near width");

    a_done_inside: assert property (@(posedge REF_CLK) disable iff (RESET)
        done_now |=> !POSITION_DONE_FLAG_N)
        else $error("done flag high inside done width");

    a_flags_mode: assert property (@(posedge REF_CLK) disable iff (RESET)
        !pos_mode |=> NEAR_FLAG_N && POSITION_DONE_FLAG_N)
        else $error("flags low outside position control");

    a_force_fwd: assert property (@(posedge REF_CLK) disable iff (RESET)
        (div_done && force_ok && !s_reg.ref_neg) |=> FORCE_CMD == $past(q16) && FORCE_DIR)
        else $error("forward force update wrong");

    a_force_rev: assert property (@(posedge REF_CLK) disable iff (RESET)
        (div_done && force_ok && s_reg.ref_neg && q16 != 16'h0000) |=>
            FORCE_CMD == 16'(16'h0000 - $past(q16)) && !FORCE_DIR)
        else $error("reverse force update wrong");

    a_force_stands: assert property (@(posedge REF_CLK) disable iff (RESET)
        !div_done |=> $stable(FORCE_CMD) && $stable(FORCE_DIR))
        else $error("force command moved between updates");

    // the divider restarts at once, so a new force value follows every 21 cycles
    a_force_period: assert property (@(posedge REF_CLK) disable iff (RESET)
        div_done |=> seq_div_quiet ##13 div_done)
        else $error("force update period wrong");

endmodule

// ==== design/servo_pkg.sv ====
// types shared by the servo control logic
`include "servo_regs.svh"
package servo_pkg;

    typedef enum logic {DIV_IDLE, DIV_RUN} div_state_e;

    typedef struct packed {
        div_state_e state;
        logic [4:0] cnt;
        logic [7:0] rem;
        logic [`QUO_W-1:0] quo;
        logic [`GAIN_W-1:0] div;
        logic done;
    } div_s;

    typedef struct packed {
        logic [`SYNC_N-1:0] sync1;
        logic [`SYNC_N-1:0] sync2;
        logic [`SYNC_N-1:0] prev;
        logic signed [`ERR_W-1:0] err;
        logic hold;
        logic near_n;
        logic done_n;
        logic signed [`FORCE_W-1:0] force_cmd;
        logic force_dir;
        logic ref_neg;
        logic [`QUO_W-1:0] ref_lat;
        logic [`GAIN_W-1:0] gain_lat;
    } ctrl_s;

endpackage

// ==== design/servo_regs.svh ====
// constants for the positioning, inhibit and force reference logic
`ifndef SERVO_REGS_SVH
`define SERVO_REGS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define ERR_W 32
`define FORCE_W 16
`define QUO_W 20
`define GAIN_W 7
`define DONE_W 8
`define NEAR_W 16
`define SYNC_N 6

// ----------------------------------------
// synchroniser bit positions
// ----------------------------------------
`define SYN_REF_FWD 0
`define SYN_REF_REV 1
`define SYN_FB_FWD 2
`define SYN_FB_REV 3
`define SYN_PROP 4
`define SYN_BLOCK 5
`define SYNC_RESET 6'h30

// ----------------------------------------
// control mode digit codes
// ----------------------------------------
`define CTRL_MODE_POSITION 4'h1
`define CTRL_MODE_FORCE_A 4'h2
`define CTRL_MODE_FORCE_B 4'h6
`define CTRL_MODE_FORCE_C 4'h8
`define CTRL_MODE_FORCE_D 4'h9

// ----------------------------------------
// setting limits and defaults
// ----------------------------------------
`define DONE_WIDTH_MAX 8'hFA
`define DONE_WIDTH_DEFAULT 8'h07
`define GAIN_MIN 7'h0A
`define GAIN_MAX 7'h64
`define GAIN_DEFAULT 7'h1E
`define FORCE_REF_MAX_MV 16'h2EE0
`define FORCE_SCALE 20'h0000A
`define DIV_LAST 5'h13

`endif

// ==== tb/host_pulse_model.sv ====
// host controller model driving the reference and motor travel pulse pins
`timescale 1ns/1ps
module host_pulse_model (
    input wire logic clk,
    output logic [3:0] pins
);
    // bit 0 ref forward, 1 ref reverse, 2 travel forward, 3 travel reverse
    initial begin
        pins = 4'h0;
    end

    // -------------------------------
    // pulse train
    // -------------------------------
    // each level lasts 4 cycles, above the 3 the synchroniser needs to see it
    task automatic send(input int sel, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            pins[sel] = 1'b1;
            repeat (4) @(negedge clk);
            pins[sel] = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask
endmodule

// ==== tb/servo_near_inhibit_force_ref_tb_top.sv ====
// self-checking bench for the near, done, inhibit and force reference logic
`timescale 1ns/1ps
module servo_near_inhibit_force_ref_tb_top;
    logic REF_CLK = 1'b0;
    logic RESET = 1'b1;
    logic [3:0] pins;
    logic PROP_N = 1'b1;
    logic BLOCK_N = 1'b1;
    logic [3:0] MODE = 4'h1;
    logic INH_EN = 1'b0;
    logic SRC_SEL = 1'b0;
    logic BLK_ASSIGNED = 1'b0;
    logic ROUTE_NEAR = 1'b1;
    logic [7:0] DONE_W = 8'h07;
    logic [15:0] NEAR_W = 16'h0014;
    logic [6:0] GAIN = 7'h1E;
    logic signed [15:0] REF_MV = 16'h0000;
    logic NEAR_N, DONE_N, LOCK, DIR;
    logic signed [31:0] ERR;
    logic signed [15:0] CMD;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;

    always #4 REF_CLK = ~REF_CLK;

    host_pulse_model host_pulse_model_i (.clk(REF_CLK), .pins(pins));

    servo_near_inhibit_force_ref servo_near_inhibit_force_ref_i (
        .REF_CLK(REF_CLK), .RESET(RESET), .PULSE_FWD(pins[0]), .PULSE_REV(pins[1]),
        .FB_FWD(pins[2]), .FB_REV(pins[3]), .PROPORTIONAL_CTRL_INPUT_N(PROP_N),
        .PULSE_BLOCK_INPUT_N(BLOCK_N), .CONTROL_MODE_DIGIT(MODE), .INHIBIT_ENABLE(INH_EN),
        .INHIBIT_SRC_SEL(SRC_SEL), .PULSE_BLOCK_ASSIGNED(BLK_ASSIGNED),
        .OUTPUT_ASSIGN_SETTING_NEAR(ROUTE_NEAR), .DONE_WIDTH_SETTING(DONE_W),
        .NEAR_WIDTH_SETTING(NEAR_W), .FORCE_INPUT_GAIN(GAIN), .FORCE_REF_MV(REF_MV),
        .NEAR_FLAG_N(NEAR_N), .POSITION_DONE_FLAG_N(DONE_N), .MOTOR_LOCK(LOCK),
        .POSITION_ERROR(ERR), .FORCE_CMD(CMD), .FORCE_DIR(DIR)
    );

    // -------------------------------
    // reporting
    // -------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // the whole run needs well under 10000 cycles
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    // -------------------------------
    // scenarios
    // -------------------------------
    task automatic near_and_done();
        check({NEAR_N, DONE_N}, 2'b00);
        host_pulse_model_i.send(0, 10);
        check(ERR, 32'h0000000A);
        check({NEAR_N, DONE_N}, 2'b01);
        ROUTE_NEAR = 1'b0;
        repeat (2) @(negedge REF_CLK);
        check(NEAR_N, 1'b1);
        ROUTE_NEAR = 1'b1;
        host_pulse_model_i.send(2, 3);
        // error equal to the width is still outside it
        check({NEAR_N, DONE_N}, 2'b01);
        host_pulse_model_i.send(2, 1);
        check({NEAR_N, DONE_N}, 2'b00);
        NEAR_W = 16'h0000;
        host_pulse_model_i.send(3, 1);
        // near width widened to the done width, so both flags leave together
        check({NEAR_N, DONE_N}, 2'b11);
        host_pulse_model_i.send(1, 7);
        check(ERR, 32'h00000000);
        check(NEAR_N, 1'b0);
        NEAR_W = 16'h0014;
    endtask

    task automatic hold_by_prop();
        INH_EN = 1'b1;
        PROP_N = 1'b0;
        repeat (2) @(negedge REF_CLK);
        check(LOCK, 1'b0);
        @(negedge REF_CLK);
        check(LOCK, 1'b1);
        host_pulse_model_i.send(0, 3);
        check(ERR, 32'h00000000);
        host_pulse_model_i.send(2, 1);
        check(ERR, 32'hFFFFFFFF);
        PROP_N = 1'b1;
        repeat (3) @(negedge REF_CLK);
        check(LOCK, 1'b0);
        host_pulse_model_i.send(0, 1);
        check(ERR, 32'h00000000);
    endtask

    task automatic hold_by_block();
        SRC_SEL = 1'b1;
        BLOCK_N = 1'b0;
        repeat (5) @(negedge REF_CLK);
        check(LOCK, 1'b0);
        BLK_ASSIGNED = 1'b1;
        repeat (2) @(negedge REF_CLK);
        check(LOCK, 1'b1);
        BLOCK_N = 1'b1;
        repeat (4) @(negedge REF_CLK);
        check(LOCK, 1'b0);
        INH_EN = 1'b0;
    endtask

    task automatic force_case(input logic [3:0] m, input logic signed [15:0] mv,
                              input logic [6:0] g, input logic signed [15:0] exp, input logic d);
        MODE = m;
        REF_MV = mv;
        GAIN = g;
        // two update periods pass the longest latency of 42 cycles
        repeat (50) @(negedge REF_CLK);
        check(32'(CMD), 32'(exp));
        check(DIR, d);
    endtask

    task automatic force_modes();
        force_case(4'h2, 16'sd3000, 7'h1E, 16'sd1000, 1'b1);
        force_case(4'h2, -16'sd300, 7'h1E, -16'sd100, 1'b0);
        force_case(4'h6, 16'sd9000, 7'h1E, 16'sd3000, 1'b1);
        force_case(4'h8, 16'sd3000, 7'h78, 16'sd300, 1'b1);
        force_case(4'h9, -16'sd3000, 7'h05, -16'sd3000, 1'b0);
        force_case(4'h1, 16'sd3000, 7'h1E, 16'sd0, 1'b1);
    endtask

    initial begin
        repeat (12) @(negedge REF_CLK);
        check({NEAR_N, DONE_N, LOCK, DIR}, 4'hD);
        check(32'(CMD), 32'h00000000);
        RESET = 1'b0;
        repeat (4) @(negedge REF_CLK);
        near_and_done();
        hold_by_prop();
        hold_by_block();
        force_modes();
        close_out();
    end
endmodule
